//--- design/mkdio_top.sv
// Matrix keypad scanner with twelve-channel discrete I/O mode.
// Functional notes
// - Scans matrices from 4x4 up to 6x6.
// - Column port bits 5..0 one-hot scanned column.
// - Column port bit 7 read shows and clears pending.
// - Column port bit 7 write sets interrupt enable.
// - Row port bits 5..0 low mark pressed key.
// - Software polls flag or interrupt, reads both ports.
// - Config bit 6 selects discrete mode, detaches scanner.
// - Twelve channels read level, drive low or release.
// - Discrete levels read from column and row ports.
// - Writing zero drives the channel low.
// - Writing one releases line for pull-up high.
// - Latches readable in row and latch ports.
`timescale 1ns/1ps
module mkdio_top (
   // Clock and reset.
   input wire logic clock,
   input wire logic resetn,
   // Host I/O port access.
   input wire mkdio_pkg::mkdio_bus_s bus,
   output logic [7:0] rdata,
   // Keypad or discrete lines, open-drain style.
   input wire mkdio_pkg::mkdio_lines_s line_in,
   output mkdio_pkg::mkdio_lines_s line_out,
   output mkdio_pkg::mkdio_lines_s line_oe,
   // Interrupt request toward the host.
   output logic keypad_irq_line
);
   import mkdio_pkg::*;

   typedef enum logic [1:0] {MKDIO_DWELL = 2'b00, MKDIO_STEP = 2'b01}
      mkdio_scan_e;

   mkdio_lines_s sync1, sync2;
   logic discrete;
   logic irq_en;
   logic pending;
   logic [11:0] latch;
   logic [5:0] col_sel;
   logic [$clog2(MKDIO_DWELL_CYC+1)-1:0] dwell;
   mkdio_scan_e scan;
   logic hit;
   logic clr_pending;
   logic [11:0] next_latch;

   // Channel order: [5:0] rows, [11:6] columns.
   logic [11:0] lvl;
   assign lvl = {sync2.col, sync2.row};

   // Pulled-up lines idle high, so the synchroniser starts there and the
   // first read after reset already shows released lines.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1 <= '1;
         sync2 <= '1;
      end else begin
         sync1 <= line_in;
         sync2 <= sync1;
      end
   end

   // Mode and interrupt enable.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         discrete <= 1'b0;
         irq_en <= 1'b0;
      end else if (bus.wr) begin
         if (bus.addr == MKDIO_CFG_PORT)
            discrete <= bus.wdata[MKDIO_MODE_BIT];
         if (bus.addr == MKDIO_COL_PORT && !discrete)
            irq_en <= bus.wdata[MKDIO_IRQ_BIT];
      end
   end

   mode_set_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.wr && bus.addr == MKDIO_CFG_PORT |=>
      discrete == $past(bus.wdata[MKDIO_MODE_BIT]))
      else $error("mode bit not taken");
   irq_keep_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.wr && discrete |=> irq_en == $past(irq_en))
      else $error("irq enable changed in discrete mode");

   // Discrete output latches; the column port write carries C1..0 and
   // R5..0, the row port write carries C5..2 in its low nibble.
   always_comb begin
      next_latch = latch;
      if (bus.wr && discrete && bus.addr == MKDIO_COL_PORT)
         next_latch[7:0] = bus.wdata;
      if (bus.wr && discrete && bus.addr == MKDIO_ROW_PORT)
         next_latch[11:8] = bus.wdata[3:0];
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         latch <= MKDIO_LATCH_RESET;
      else
         latch <= next_latch;
   end

   // Keypad mode must leave the latches alone, so a later switch to
   // discrete mode does not drive lines left over from keypad writes.
   latch_hold_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.wr && !discrete |=> latch == $past(latch))
      else $error("latch changed in keypad mode");
   latch_take_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.wr && discrete && bus.addr == MKDIO_COL_PORT |=>
      latch[7:0] == $past(bus.wdata))
      else $error("latch write not taken");

   // Column scanner; it holds each column long enough for rows to settle.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         col_sel <= MKDIO_COL_FIRST;
         dwell <= '0;
         scan <= MKDIO_DWELL;
      end else begin
         case (scan)
            MKDIO_DWELL: begin
               if (dwell == ($bits(dwell))'(MKDIO_DWELL_CYC - 1)) begin
                  dwell <= '0;
                  scan <= MKDIO_STEP;
               end else begin
                  dwell <= dwell + ($bits(dwell))'(1);
               end
            end
            MKDIO_STEP: begin
               col_sel <= {col_sel[4:0], col_sel[5]};
               scan <= MKDIO_DWELL;
            end
            default: scan <= MKDIO_DWELL;
         endcase
      end
   end

   col_hot_a: assert property (
      @(posedge clock) disable iff (!resetn)
      $onehot(col_sel))
      else $error("column select not one-hot");
   col_step_a: assert property (
      @(posedge clock) disable iff (!resetn)
      scan == MKDIO_STEP |=>
      col_sel == {$past(col_sel[4:0]), $past(col_sel[5])})
      else $error("column did not advance");
   col_hold_a: assert property (
      @(posedge clock) disable iff (!resetn)
      scan == MKDIO_DWELL |=> $stable(col_sel))
      else $error("column moved during dwell");
   dwell_cap_a: assert property (
      @(posedge clock) disable iff (!resetn)
      dwell < ($bits(dwell))'(MKDIO_DWELL_CYC))
      else $error("dwell counter overran");
   step_once_a: assert property (
      @(posedge clock) disable iff (!resetn)
      scan == MKDIO_STEP |=> scan == MKDIO_DWELL)
      else $error("step state held");

   // A key is sampled at the end of the dwell, once the row lines settled.
   assign hit = !discrete && scan == MKDIO_STEP && sync2.row != 6'h3f;
   assign clr_pending = bus.rd && bus.addr == MKDIO_COL_PORT && !discrete;

   // Set wins over the read clear so a key is never lost.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         pending <= 1'b0;
      else if (hit)
         pending <= 1'b1;
      else if (clr_pending)
         pending <= 1'b0;
   end

   sequence key_seen_s;
      hit;
   endsequence
   sequence flag_up_s;
      ##1 pending;
   endsequence

   pend_set_a: assert property (
      @(posedge clock) disable iff (!resetn)
      key_seen_s |-> flag_up_s)
      else $error("pending not set after key");
   pend_clr_a: assert property (
      @(posedge clock) disable iff (!resetn)
      clr_pending && !hit |=> !pending)
      else $error("pending not cleared by read");
   pend_hold_a: assert property (
      @(posedge clock) disable iff (!resetn)
      pending && !clr_pending |=> pending)
      else $error("pending dropped without a read");

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn)
         keypad_irq_line <= 1'b0;
      else
         keypad_irq_line <= pending && irq_en;
   end

   // The line is a registered copy, so it trails pending by one clock.
   sequence irq_armed_s;
      pending && irq_en;
   endsequence
   sequence irq_up_s;
      ##1 keypad_irq_line;
   endsequence

   irq_follow_a: assert property (
      @(posedge clock) disable iff (!resetn)
      irq_armed_s |-> irq_up_s)
      else $error("irq not raised for pending key");
   irq_gate_a: assert property (
      @(posedge clock) disable iff (!resetn)
      !irq_en |=> !keypad_irq_line)
      else $error("irq raised while disabled");
   irq_low_a: assert property (
      @(posedge clock) disable iff (!resetn)
      !pending |=> !keypad_irq_line)
      else $error("irq raised with nothing pending");

   // Line drive: columns driven low one at a time in keypad mode, the
   // latches in discrete mode. A one only releases the line.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         line_out <= '0;
         line_oe <= '0;
      end else begin
         line_out <= '0;
         if (discrete) begin
            line_oe.row <= ~latch[5:0];
            line_oe.col <= ~latch[11:6];
         end else begin
            line_oe.row <= '0;
            line_oe.col <= col_sel;
         end
      end
   end

   drive_low_a: assert property (
      @(posedge clock) disable iff (!resetn)
      discrete && !latch[0] |=> line_oe.row[0] && !line_out.row[0])
      else $error("zero latch not driven low");
   release_a: assert property (
      @(posedge clock) disable iff (!resetn)
      discrete && latch[6] |=> !line_oe.col[0])
      else $error("one latch not released");
   scan_detach_a: assert property (
      @(posedge clock) disable iff (!resetn)
      discrete |=> line_oe.col == ~$past(latch[11:6]))
      else $error("scanner still drives columns");
   col_drive_a: assert property (
      @(posedge clock) disable iff (!resetn)
      !discrete |=> line_oe.col == $past(col_sel) && line_oe.row == 6'h00)
      else $error("keypad drive wrong");

   // Read data, registered one cycle after the read strobe.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata <= '0;
      end else if (bus.rd) begin
         case (bus.addr)
            MKDIO_COL_PORT:
               rdata <= discrete ? lvl[7:0]
                  : {pending, 1'b0, col_sel};
            MKDIO_ROW_PORT:
               rdata <= discrete ? {latch[3:0], lvl[11:8]}
                  : {2'b00, sync2.row};
            MKDIO_LATCH_PORT:
               rdata <= {latch[11:6], latch[5:4]};
            MKDIO_CFG_PORT:
               rdata <= {1'b0, discrete, 6'h00};
            default: rdata <= '0;
         endcase
      end
   end

   col_read_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_COL_PORT && !discrete |=>
      rdata == {$past(pending), 1'b0, $past(col_sel)})
      else $error("column port read wrong");
   rowread_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_ROW_PORT && !discrete |=>
      rdata[5:0] == $past(sync2.row))
      else $error("row port read wrong");
   lvl_read_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_COL_PORT && discrete |=>
      rdata == $past(lvl[7:0]))
      else $error("line levels read wrong");
   row_latch_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_ROW_PORT && discrete |=>
      rdata == {$past(latch[3:0]), $past(lvl[11:8])})
      else $error("row port latch read wrong");
   latch_read_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_LATCH_PORT |=>
      rdata == {$past(latch[11:6]), $past(latch[5:4])})
      else $error("latch port read wrong");
   cfg_read_a: assert property (
      @(posedge clock) disable iff (!resetn)
      bus.rd && bus.addr == MKDIO_CFG_PORT |=>
      rdata == {1'b0, $past(discrete), 6'h00})
      else $error("mode read wrong");
endmodule // mkdio_top

//--- design/mkdio_pkg.sv
// Package for the matrix keypad and discrete I/O block.
package mkdio_pkg;
   localparam logic [9:0] MKDIO_COL_PORT = 10'h315;
   localparam logic [9:0] MKDIO_ROW_PORT = 10'h316;
   localparam logic [9:0] MKDIO_LATCH_PORT = 10'h31b;
   localparam logic [9:0] MKDIO_CFG_PORT = 10'h310;
   localparam int MKDIO_IRQ_BIT = 7;
   localparam int MKDIO_MODE_BIT = 6;
   localparam logic [11:0] MKDIO_LATCH_RESET = 12'hfff;
   // Column dwell time in ns per scan step.
   localparam int MKDIO_DWELL_NS = 1000;
   localparam int MKDIO_CLK_NS = 4;
   localparam int MKDIO_DWELL_CYC = MKDIO_DWELL_NS / MKDIO_CLK_NS;
   localparam logic [5:0] MKDIO_COL_FIRST = 6'h01;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } mkdio_bus_s;
   typedef struct packed {
      logic [5:0] col;
      logic [5:0] row;
   } mkdio_lines_s;
endpackage

//--- sim/mkdio_keypad_model.sv
// Passive keypad and pulled-up field lines facing the scanner.
`timescale 1ns/1ps
module mkdio_keypad_model (
   // Drive enables from the block.
   input wire mkdio_pkg::mkdio_lines_s line_oe,
   // Keys held along one row.
   input wire logic press,
   input wire logic [2:0] key_row,
   // Line levels seen by the block.
   output mkdio_pkg::mkdio_lines_s line_in
);
   import mkdio_pkg::*;
   logic short;
   // A held row of keys ties that row to any column pulled low.
   assign short = press && (line_oe.col != 6'h00);
   always_comb begin
      line_in.col = ~line_oe.col;
      line_in.row = ~line_oe.row;
      if (short) begin
         line_in.row[key_row] = 1'b0;
      end
   end
endmodule // mkdio_keypad_model

//--- sim/testbench.sv
// Self-checking bench for the keypad scanner and discrete I/O block.
`timescale 1ns/1ps
module testbench;
   import mkdio_pkg::*;
   typedef struct {
      logic w;
      logic [9:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } mkdio_row_s;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   mkdio_bus_s bus = '0;
   logic [7:0] rdata;
   mkdio_lines_s line_in, line_out, line_oe;
   logic keypad_irq_line;
   logic press = 1'b0;
   logic [7:0] seen;
   logic [5:0] cols;
   int mismatches = 0;
   int comparisons = 0;
   // Writes carry no expectation; reads follow the writes they depend on.
   mkdio_row_s rows [11] = '{
      '{0, 10'h315, 8'h00, 8'h01}, '{0, 10'h316, 8'h00, 8'h3f},
      '{0, 10'h31b, 8'h00, 8'hff}, '{0, 10'h300, 8'h00, 8'h00},
      '{1, 10'h310, 8'h40, 8'h00}, '{1, 10'h315, 8'ha5, 8'h00},
      '{1, 10'h316, 8'h06, 8'h00}, '{0, 10'h310, 8'h00, 8'h40},
      '{0, 10'h315, 8'h00, 8'ha5}, '{0, 10'h316, 8'h00, 8'h56},
      '{0, 10'h31b, 8'h00, 8'h6a}};
   mkdio_top dut (.clock(clock), .resetn(resetn), .bus(bus),
      .rdata(rdata), .line_in(line_in), .line_out(line_out),
      .line_oe(line_oe), .keypad_irq_line(keypad_irq_line));
   mkdio_keypad_model keys (.line_oe(line_oe), .press(press),
      .key_row(3'h3), .line_in(line_in));
   initial begin
      forever #2 clock = ~clock;
   end
   task automatic acc(input logic w, input logic [9:0] a,
      input logic [7:0] d);
      @(posedge clock);
      bus <= '{rd: ~w, wr: w, addr: a, wdata: d};
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
      seen = rdata;
   endtask
   task automatic chk(input string n, input logic [7:0] s,
      input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // The scan tests need about 3200 cycles; allow generous slack.
   initial begin
      repeat (8000) @(posedge clock);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) begin
            chk("port read", seen, rows[i].e);
         end
      end
      chk("column drive", {2'h0, line_oe.col}, 8'h25);
      chk("row drive", {2'h0, line_oe.row}, 8'h1a);
      chk("line out", {2'h0, line_out.row | line_out.col}, 8'h00);
      $display("table test done");
      acc(1'b1, 10'h310, 8'h00);
      press <= 1'b1;
      repeat (1600) @(posedge clock);
      chk("irq masked", {7'h0, keypad_irq_line}, 8'h00);
      acc(1'b1, 10'h315, 8'h80);
      repeat (4) @(posedge clock);
      chk("irq raised", {7'h0, keypad_irq_line}, 8'h01);
      acc(1'b0, 10'h316, 8'h00);
      chk("row pressed", seen, 8'h37);
      acc(1'b0, 10'h315, 8'h00);
      seen = {seen[7], 6'h0, $countones(seen[5:0]) == 1};
      chk("pending", seen, 8'h81);
      acc(1'b0, 10'h315, 8'h00);
      chk("pending cleared", seen & 8'h80, 8'h00);
      // Reads one column step (251 cycles) apart must see every column in turn.
      cols = '0;
      repeat (6) begin
         repeat (248) @(posedge clock);
         acc(1'b0, 10'h315, 8'h00);
         cols = cols | seen[5:0];
      end
      chk("all columns", {2'h0, cols}, 8'h3f);
      press <= 1'b0;
      $display("scan test done");
      resetn <= 1'b0;
      @(posedge clock);
      chk("irq in reset", {7'h0, keypad_irq_line}, 8'h00);
      resetn <= 1'b1;
      acc(1'b0, 10'h310, 8'h00);
      chk("mode after reset", seen, 8'h00);
      acc(1'b0, 10'h315, 8'h00);
      chk("column after reset", seen, 8'h01);
      $display("reset test done");
      summarize();
   end
endmodule // testbench
